// [rtl/sdg_consts.svh]
// constants of the three-channel step and direction generator
`ifndef SDG_CONSTS_SVH
`define SDG_CONSTS_SVH

`define SDG_CHANNELS     3
`define SDG_CLK_HZ       125000000
`define SDG_GEN_HZ       25000000
`define SDG_DIV_RATIO    (`SDG_CLK_HZ / `SDG_GEN_HZ)
`define SDG_DIV_W        3

`define SDG_REG_RATE0    8'h12
`define SDG_REG_POS0     8'h15
`define SDG_REG_TGT0     8'h18
`define SDG_REG_LEN      8'h21
`define SDG_REG_DLY      8'h22
`define SDG_REG_CFG      8'h23

`define SDG_FIELD_W      16
`define SDG_CFG_STRIDE   8
`define SDG_CFG_W        24
`define SDG_CFG_EN       0
`define SDG_CFG_MODE     1
`define SDG_CFG_SPOL     2
`define SDG_CFG_DPOL     3
`define SDG_SIGN         31

`endif

// [rtl/sdg_pkg.sv]
// types of the step and direction generator
`include "sdg_consts.svh"
package sdg_pkg;
    typedef struct packed {
        logic [`SDG_DIV_W-1:0]                div;
        logic                                 tick;
        logic [`SDG_CHANNELS-1:0][31:0]       rate, pos, remain, acc;
        logic [`SDG_CHANNELS-1:0][15:0]       wcnt, dcnt;
        logic [`SDG_CHANNELS-1:0]             dir;
        logic [47:0]                          len, dly;
        logic [`SDG_CFG_W-1:0]                cfg;
        logic [`SDG_CHANNELS-1:0]             step_o, dir_o;
        logic [63:0]                          rdata;
    } sdg_state_t;
endpackage

// [rtl/sdg_step_dir_gen.sv]
// three-channel step and direction pulse generator with its register port
//
// Contract
// - three independent channels, each with own registers and output pairs
// - writable 32-bit accumulation constant sets step interval and frequency
// - accumulation constant is signed two's complement
// - sign bit of the constant drives the direction pair
// - read-only signed step counter moves up or down per pulse by direction
// - step target may be rewritten at any time, even while stepping
// - no step pulses while the remaining target is zero, unless the channel's mode bit selects continuous mode
// - reading the target returns the pulses still outstanding
// - pulse width is a 16-bit count of 25 MHz cycles per channel
// - 16-bit delay in 25 MHz cycles after a direction change before stepping
// - separate polarity selects for step pair and direction pair
`timescale 1ns/100ps
`include "sdg_consts.svh"
module sdg_step_dir_gen (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_idx_i,
    input  wire logic [63:0] reg_wdata_i,
    output logic      [63:0] reg_rdata_o,
    output logic             step_out_0_o,
    output logic             step_out_0_inv_o,
    output logic             step_out_1_o,
    output logic             step_out_1_inv_o,
    output logic             step_out_2_o,
    output logic             step_out_2_inv_o,
    output logic             dir_out_0_o,
    output logic             dir_out_0_inv_o,
    output logic             dir_out_1_o,
    output logic             dir_out_1_inv_o,
    output logic             dir_out_2_o,
    output logic             dir_out_2_inv_o
);
    sdg_pkg::sdg_state_t st_q;
    sdg_pkg::sdg_state_t st_d;
    logic [`SDG_CHANNELS-1:0] start_c;

    // one-hot channel select for a block of three per-channel registers
    function automatic logic [`SDG_CHANNELS-1:0] ch_sel(input logic [7:0] idx,
                                                        input logic [7:0] base);
        logic [`SDG_CHANNELS-1:0] r;
        r = '0;
        for (int k = 0; k < `SDG_CHANNELS; k++) begin
            if (idx == base + 8'(k)) begin
                r[k] = 1'b1;
            end
        end
        return r;
    endfunction

    always_comb begin
        logic [31:0]              mag;
        logic [32:0]              sum;
        logic [15:0]              plen;
        logic [15:0]              pdly;
        logic                     en;
        logic                     cont;
        logic [`SDG_CHANNELS-1:0] wr_rate;
        logic [`SDG_CHANNELS-1:0] wr_tgt;
        logic [`SDG_CHANNELS-1:0] rd_pos;
        logic [`SDG_CHANNELS-1:0] rd_tgt;
        mag     = '0;
        sum     = '0;
        plen    = '0;
        pdly    = '0;
        en      = 1'b0;
        cont    = 1'b0;
        start_c = '0;
        st_d    = st_q;
        wr_rate = reg_wr_i ? ch_sel(reg_idx_i, `SDG_REG_RATE0) : '0;
        wr_tgt  = reg_wr_i ? ch_sel(reg_idx_i, `SDG_REG_TGT0) : '0;
        rd_pos  = reg_rd_i ? ch_sel(reg_idx_i, `SDG_REG_POS0) : '0;
        rd_tgt  = reg_rd_i ? ch_sel(reg_idx_i, `SDG_REG_TGT0) : '0;

        // 25 MHz enable from the 125 MHz clock
        if (st_q.div == `SDG_DIV_W'(`SDG_DIV_RATIO - 1)) begin
            st_d.div = '0;
        end else begin
            st_d.div = st_q.div + `SDG_DIV_W'(1);
        end
        st_d.tick = (st_q.div == `SDG_DIV_W'(`SDG_DIV_RATIO - 1));

        if (reg_wr_i && reg_idx_i == `SDG_REG_LEN) begin
            st_d.len = reg_wdata_i[47:0];
        end
        if (reg_wr_i && reg_idx_i == `SDG_REG_DLY) begin
            st_d.dly = reg_wdata_i[47:0];
        end
        if (reg_wr_i && reg_idx_i == `SDG_REG_CFG) begin
            st_d.cfg = reg_wdata_i[`SDG_CFG_W-1:0];
        end

        for (int c = 0; c < `SDG_CHANNELS; c++) begin
            en   = st_q.cfg[`SDG_CFG_STRIDE*c + `SDG_CFG_EN];
            cont = st_q.cfg[`SDG_CFG_STRIDE*c + `SDG_CFG_MODE];
            plen = st_q.len[`SDG_FIELD_W*c +: `SDG_FIELD_W];
            pdly = st_q.dly[`SDG_FIELD_W*c +: `SDG_FIELD_W];
            // magnitude of the signed constant
            mag  = st_q.rate[c][`SDG_SIGN] ? (~st_q.rate[c] + 32'h0000_0001)
                                           : st_q.rate[c];
            sum  = {1'b0, st_q.acc[c]} + {1'b0, mag};

            if (st_q.tick) begin
                if (st_q.wcnt[c] != 16'h0000) begin
                    st_d.wcnt[c] = st_q.wcnt[c] - 16'h0001;
                end
                if (st_q.dir[c] != st_q.rate[c][`SDG_SIGN]) begin
                    st_d.dir[c]  = st_q.rate[c][`SDG_SIGN];
                    st_d.dcnt[c] = pdly;
                end else if (st_q.dcnt[c] != 16'h0000) begin
                    st_d.dcnt[c] = st_q.dcnt[c] - 16'h0001;
                end
                if (!en) begin
                    st_d.acc[c] = '0;
                end else begin
                    st_d.acc[c] = sum[31:0];
                    // a carry landing inside a pulse or the setup delay is dropped
                    start_c[c] = sum[32] && st_q.wcnt[c] == 16'h0000
                                 && st_q.dcnt[c] == 16'h0000
                                 && st_q.dir[c] == st_q.rate[c][`SDG_SIGN]
                                 && (cont || st_q.remain[c] != 32'h0000_0000);
                end
                if (start_c[c]) begin
                    // a zero length still gives a one-tick pulse
                    st_d.wcnt[c] = (plen == 16'h0000) ? 16'h0001 : plen;
                    st_d.pos[c]  = st_q.dir[c] ? st_q.pos[c] - 32'h0000_0001
                                               : st_q.pos[c] + 32'h0000_0001;
                    if (!cont) begin
                        st_d.remain[c] = st_q.remain[c] - 32'h0000_0001;
                    end
                end
            end
            if (wr_rate[c]) begin
                st_d.rate[c] = reg_wdata_i[31:0];
            end
            // a software write beats a same-cycle decrement
            if (wr_tgt[c]) begin
                st_d.remain[c] = reg_wdata_i[31:0];
            end
            st_d.step_o[c] = (st_d.wcnt[c] != 16'h0000)
                             ^ st_q.cfg[`SDG_CFG_STRIDE*c + `SDG_CFG_SPOL];
            st_d.dir_o[c]  = st_d.dir[c]
                             ^ st_q.cfg[`SDG_CFG_STRIDE*c + `SDG_CFG_DPOL];
        end

        if (reg_rd_i) begin
            st_d.rdata = '0;
            for (int c = 0; c < `SDG_CHANNELS; c++) begin
                if (rd_pos[c]) begin
                    st_d.rdata = {32'h0000_0000, st_q.pos[c]};
                end
                if (rd_tgt[c]) begin
                    st_d.rdata = {32'h0000_0000, st_q.remain[c]};
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata_o      = st_q.rdata;
    assign step_out_0_o     = st_q.step_o[0];
    assign step_out_0_inv_o = ~st_q.step_o[0];
    assign step_out_1_o     = st_q.step_o[1];
    assign step_out_1_inv_o = ~st_q.step_o[1];
    assign step_out_2_o     = st_q.step_o[2];
    assign step_out_2_inv_o = ~st_q.step_o[2];
    assign dir_out_0_o      = st_q.dir_o[0];
    assign dir_out_0_inv_o  = ~st_q.dir_o[0];
    assign dir_out_1_o      = st_q.dir_o[1];
    assign dir_out_1_inv_o  = ~st_q.dir_o[1];
    assign dir_out_2_o      = st_q.dir_o[2];
    assign dir_out_2_inv_o  = ~st_q.dir_o[2];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    tick_period_a: assert property (st_q.tick |=> !st_q.tick [*4] ##1 st_q.tick)
        else $error("generator enable not one in five cycles");
    step_block_a: assert property (start_c[0] |=> st_q.wcnt[0] != 16'h0000
        && st_q.step_o[0] != st_q.cfg[`SDG_CFG_SPOL])
        else $error("channel 0 pulse did not start");
    sign_dir_a: assert property (st_q.tick && st_q.dir[0] != st_q.rate[0][`SDG_SIGN]
        |=> ##1 dir_out_0_o == ($past(st_q.rate[0][`SDG_SIGN], 2) ^ st_q.cfg[`SDG_CFG_DPOL])
        || $past(reg_wr_i))
        else $error("direction output does not follow rate sign");
    position_step_a: assert property (start_c[0] |=> st_q.pos[0] ==
        ($past(st_q.dir[0]) ? $past(st_q.pos[0]) - 32'h0000_0001
                            : $past(st_q.pos[0]) + 32'h0000_0001))
        else $error("step counter did not follow the pulse");
    target_write_a: assert property (reg_wr_i && reg_idx_i == `SDG_REG_TGT0
        |=> st_q.remain[0] == $past(reg_wdata_i[31:0]))
        else $error("target write lost");
    zero_stop_a: assert property (!st_q.cfg[`SDG_CFG_MODE]
        && st_q.remain[0] == 32'h0000_0000 |-> !start_c[0])
        else $error("pulse issued with zero target");
    remain_read_a: assert property (reg_rd_i && reg_idx_i == `SDG_REG_TGT0
        |=> reg_rdata_o == {32'h0000_0000, $past(st_q.remain[0])})
        else $error("target read not remaining count");
    dir_delay_a: assert property (st_q.tick && st_q.dir[0] != st_q.rate[0][`SDG_SIGN]
        |=> st_q.dcnt[0] == st_q.dly[15:0] || $past(reg_wr_i))
        else $error("direction setup delay not loaded");
    disabled_idle_a: assert property (!st_q.cfg[`SDG_CFG_EN] |-> !start_c[0])
        else $error("disabled channel stepped");
    remain_dec_a: assert property (start_c[0] && !st_q.cfg[`SDG_CFG_MODE] && !reg_wr_i
        |=> st_q.remain[0] == $past(st_q.remain[0]) - 32'h0000_0001)
        else $error("remaining target not decremented");

    pulse_cov: cover property (start_c[0] ##1 st_q.remain[0] == 32'h0000_0000);
    delay_cov: cover property (st_q.dcnt[0] != 16'h0000 ##[1:100] start_c[0]);
    cont_cov:  cover property (st_q.cfg[`SDG_CFG_MODE] && start_c[0]);
    rev_cov:   cover property (start_c[0] && st_q.dir[0]);
endmodule

// [testbench/sdg_drv_model.sv]
// stepper driver input model: counts step pulses, measures width, checks the pair
`timescale 1ns/100ps
module sdg_drv_model #(
    parameter logic POL = 1'b0
) (
    input  wire logic clk_i,
    input  wire logic step_i,
    input  wire logic step_inv_i,
    input  wire logic dir_i,
    output int        pulses_o,
    output int        width_o,
    output int        pair_err_o,
    output int        setup_o
);
    // starts as active so an idle inverted line is not taken for a pulse
    logic act_q   = 1'b1;
    logic dir_q   = 1'b0;
    logic fresh_q = 1'b0;
    int   run     = 0;
    int   since   = 0;
    initial begin
        pulses_o = 0;
        width_o = 0;
        pair_err_o = 0;
        setup_o = 0;
    end
    always @(posedge clk_i) begin
        if (step_inv_i !== ~step_i) begin
            pair_err_o <= pair_err_o + 1;
        end
        if ((step_i ^ POL) === 1'b1) begin
            if (!act_q) begin
                pulses_o <= pulses_o + 1;
                // only the first pulse after a reversal shows the setup time
                if (fresh_q) begin
                    setup_o <= since;
                    fresh_q <= 1'b0;
                end
            end
            run <= run + 1;
        end else if (act_q) begin
            width_o <= run;
            run <= 0;
        end
        act_q <= (step_i ^ POL) === 1'b1;
        // cycles since the direction line last moved
        if (dir_i !== dir_q) begin
            since   <= 0;
            fresh_q <= 1'b1;
        end else begin
            since <= since + 1;
        end
        dir_q <= dir_i;
    end
endmodule

// [testbench/tb.sv]
// self-checking testbench of the step and direction generator
`timescale 1ns/100ps
`include "sdg_consts.svh"
module tb;
    logic        clk_i       = 1'b0;
    logic        rst_b_i     = 1'b0;
    logic        reg_wr_i    = 1'b0;
    logic        reg_rd_i    = 1'b0;
    logic [7:0]  reg_idx_i   = 8'h00;
    logic [63:0] reg_wdata_i = 64'h0;
    logic [63:0] reg_rdata_o;
    wire logic [2:0] st, sti, dr, dri;
    int          pls [3];
    int          base [3];
    int          setup [3];
    int          wid [3];
    int          perr [3];
    int          nexp [3];
    logic [31:0] rate [3];
    logic [63:0] v;
    int          fail_count = 0;
    int          compares   = 0;

    sdg_step_dir_gen u_sdg_step_dir_gen (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_idx_i(reg_idx_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .step_out_0_o(st[0]), .step_out_0_inv_o(sti[0]), .step_out_1_o(st[1]),
        .step_out_1_inv_o(sti[1]), .step_out_2_o(st[2]), .step_out_2_inv_o(sti[2]),
        .dir_out_0_o(dr[0]), .dir_out_0_inv_o(dri[0]), .dir_out_1_o(dr[1]),
        .dir_out_1_inv_o(dri[1]), .dir_out_2_o(dr[2]), .dir_out_2_inv_o(dri[2]));
    sdg_drv_model #(.POL(1'b0)) m0 (.clk_i(clk_i), .step_i(st[0]), .step_inv_i(sti[0]),
        .dir_i(dr[0]), .pulses_o(pls[0]), .width_o(wid[0]), .pair_err_o(perr[0]),
        .setup_o(setup[0]));
    sdg_drv_model #(.POL(1'b0)) m1 (.clk_i(clk_i), .step_i(st[1]), .step_inv_i(sti[1]),
        .dir_i(dr[1]), .pulses_o(pls[1]), .width_o(wid[1]), .pair_err_o(perr[1]),
        .setup_o(setup[1]));
    sdg_drv_model #(.POL(1'b1)) m2 (.clk_i(clk_i), .step_i(st[2]), .step_inv_i(sti[2]),
        .dir_i(dr[2]), .pulses_o(pls[2]), .width_o(wid[2]), .pair_err_o(perr[2]),
        .setup_o(setup[2]));

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    task automatic wr(input logic [7:0] i, input logic [63:0] d);
        reg_idx_i = i;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(posedge clk_i) #1 reg_wr_i = 1'b0;
        // an idle edge keeps a following write from re-raising the strobe at once
        @(posedge clk_i);
        #1;
    endtask

    // read data stands right after the edge that takes the read; the task samples it one edge later
    task automatic rd(input logic [7:0] i);
        reg_idx_i = i;
        reg_rd_i = 1'b1;
        @(posedge clk_i) #1 reg_rd_i = 1'b0;
        @(posedge clk_i) #1 v = reg_rdata_o;
    endtask

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // position as the 32-bit two's complement count, zero-extended
    task automatic verify(input int c);
        rd(8'(`SDG_REG_TGT0 + c));
        chk("remaining", 64'h0, v);
        rd(8'(`SDG_REG_POS0 + c));
        chk("position", {32'h0, rate[c][31] ? 32'(-nexp[c]) : 32'(nexp[c])}, v);
        chk("pulses", 64'(nexp[c]), 64'(pls[c] - base[c]));
        chk("width", 64'((c + 1) * 5), 64'(wid[c]));
        chk("step pair", 64'h0, 64'(perr[c]));
        chk("direction", {63'h0, rate[c][31] ^ (c == 1)}, {63'h0, dr[c]});
        chk("direction pair", {63'h0, ~dr[c]}, {63'h0, dri[c]});
    endtask

    task automatic results();
        if (fail_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        wait_clk(4000);
        fail_count++;
        results();
    end

    initial begin
        void'($urandom(73445));
        wait_clk(16);
        rst_b_i = 1'b1;
        wait_clk(1);
        for (int c = 0; c < 3; c++) begin
            nexp[c] = $urandom_range(5, 2);
            rate[c] = $urandom_range(32'h3FFF_FFFF, 32'h2000_0000);
            if (c > 0) rate[c] = -rate[c];
            wr(8'(`SDG_REG_RATE0 + c), {32'h0, rate[c]});
            wr(8'(`SDG_REG_TGT0 + c), 64'(nexp[c]));
        end
        wr(`SDG_REG_LEN, 64'h0003_0002_0001);
        wr(`SDG_REG_DLY, 64'h0004_0004_0004);
        wr(`SDG_REG_CFG, 64'h05_09_01);
        // an inverted step line reads as active until its polarity is set
        foreach (base[k]) base[k] = pls[k];
        wait_clk(600);
        for (int c = 0; c < 3; c++) verify(c);
        nexp[0] += 2;
        wr(`SDG_REG_TGT0, 64'h2);
        wait_clk(300);
        verify(0);
        // continuous mode runs past the target, then disabling freezes it
        wr(`SDG_REG_CFG, 64'h07_09_01);
        wait_clk(300);
        // polarity kept while disabling, so the idle line stays inactive
        wr(`SDG_REG_CFG, 64'h04_09_01);
        wait_clk(100);
        chk("continuous", 64'h1, {63'h0, (pls[2] - base[2]) > nexp[2]});
        rd(8'(`SDG_REG_POS0 + 2));
        chk("position", {32'h0, 32'(base[2] - pls[2])}, v);
        rd(`SDG_REG_RATE0);
        chk("rate read", 64'h0, v);
        wr(`SDG_REG_POS0, {32'h0, $urandom()});
        rd(`SDG_REG_POS0);
        chk("position ro", {32'h0, 32'(nexp[0])}, v);
        // reversing channel 0 must hold the first pulse back by the setup delay
        rate[0] = -$urandom_range(32'h3FFF_FFFF, 32'h2000_0000);
        wr(`SDG_REG_RATE0, {32'h0, rate[0]});
        wr(`SDG_REG_TGT0, 64'h3);
        wait_clk(300);
        rd(`SDG_REG_POS0);
        chk("position", {32'h0, 32'(nexp[0] - 3)}, v);
        chk("pulses", 64'(nexp[0] + 3), 64'(pls[0] - base[0]));
        chk("setup delay", 64'h1, {63'h0, setup[0] >= 20});
        chk("direction", 64'h1, {63'h0, dr[0]});
        rd(8'h24);
        chk("unmapped", 64'h0, v);
        results();
    end
endmodule
